// file: srtc_cfg.svh
`ifndef SRTC_CFG_SVH
`define SRTC_CFG_SVH

// Register map (word offsets on the plain register port)
`define SRTC_ADDR_TIMING 4'h0
`define SRTC_ADDR_STATUS 4'h1
`define SRTC_ADDR_CSMODE 4'h2

// Timing register layout and reset value
`define SRTC_TIMING_RESET 16'h2115
`define SRTC_TIMING_WMASK 16'hFF30
`define SRTC_RTP_MSB 15
`define SRTC_RTP_LSB 10
`define SRTC_RC_MSB 9
`define SRTC_RC_LSB 8
`define SRTC_RP_MSB 5
`define SRTC_RP_LSB 4

// Timing arithmetic
`define SRTC_RTP_UNIT 16
`define SRTC_RC_BASE 5
`define SRTC_RP_BASE 1

// Chip-select gating
`define SRTC_MODE_SDRAM 2'h1
`define SRTC_WS_SDRAM 5'h1F
`define SRTC_CSMODE_RESET 8'h00

`endif

// file: srtc_pkg.sv
package srtc_pkg;
	typedef enum logic [1:0] {
		SRTC_IDLE = 2'h0,
		SRTC_REFRESH = 2'h1,
		SRTC_PRECHARGE = 2'h3
	} srtc_state_type;
endpackage

// file: srtc_down_counter.sv
`timescale 1ns/10ps
module srtc_down_counter #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	// Status
	output logic [WIDTH-1:0] count,
	output logic zero
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;

	always_comb begin
		count_d = count_q;
		if (load) begin
			count_d = loadValue;
		end else if (count_q != '0) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
	assign zero = (count_q == '0);
endmodule

// file: srtc_refresh_timing.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "srtc_cfg.svh"
module srtc_refresh_timing
	import srtc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	// Controller side
	input wire logic accessBusy,
	input wire logic prechargeStart,
	output logic refreshCmd,
	output logic cmdHold,
	output logic prechargeActive,
	output logic refreshPending,
	output logic sdramEnabled,
	output logic [1:0] refreshStateCount,
	output logic [1:0] prechargeCycles
);
	// Software-visible registers
	logic [15:0] timing_q;
	logic [15:0] timing_d;
	logic [7:0] csMode_q;
	logic [7:0] csMode_d;
	logic [15:0] rdData_q;
	logic [15:0] rdData_d;
	// Refresh sequencer
	logic pending_q;
	logic pending_d;
	srtc_state_type state_q;
	srtc_state_type state_d;
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic [5:0] refreshPrescaler;
	logic [1:0] busInterfaceMode;
	logic [4:0] waitStateField;
	logic [9:0] intervalLoad;
	logic intervalReload;
	logic intervalZero;
	logic [9:0] intervalCount;
	logic intervalExpired;

	// Register write helpers and status word
	logic [15:0] timingWrite;
	logic [15:0] statusWord;
	logic [7:0] csModeWrite;

	assign refreshPrescaler = timing_q[`SRTC_RTP_MSB:`SRTC_RTP_LSB];
	assign refreshStateCount = timing_q[`SRTC_RC_MSB:`SRTC_RC_LSB];
	assign prechargeCycles = timing_q[`SRTC_RP_MSB:`SRTC_RP_LSB];
	assign busInterfaceMode = csMode_q[6:5];
	assign waitStateField = csMode_q[4:0];
	// Mode 01 with wait states 0x1F selects SDRAM timing
	assign sdramEnabled = (busInterfaceMode == `SRTC_MODE_SDRAM) && (waitStateField == `SRTC_WS_SDRAM);

	// Prescaler of zero would wrap the load to 0x3FF and refresh every 1024 cycles; treat it as stopped
	assign intervalLoad = 10'(refreshPrescaler * `SRTC_RTP_UNIT - 1);
	assign intervalExpired = intervalZero && sdramEnabled && (refreshPrescaler != 6'h00);
	assign intervalReload = intervalExpired || !sdramEnabled;

	srtc_down_counter #(
		.WIDTH(10)
	) intervalTimer (
		.core_clk(core_clk),
		.rst(rst),
		.load(intervalReload),
		.loadValue(intervalLoad),
		.count(intervalCount),
		.zero(intervalZero)
	);

	// Writable bits follow software, reserved bits hold their reset value
	// Constant mask, so each bit folds to a plain wire
	localparam logic [15:0] TimingWriteMask = `SRTC_TIMING_WMASK;
	localparam logic [15:0] TimingResetValue = `SRTC_TIMING_RESET;
	for (genvar bitIdx = 0; bitIdx < 16; bitIdx++) begin : gen_timing_write
		if (TimingWriteMask[bitIdx]) begin : gen_rw
			assign timingWrite[bitIdx] = regWrData[bitIdx];
		end else begin : gen_fixed
			assign timingWrite[bitIdx] = TimingResetValue[bitIdx];
		end
	end

	// Bit 7 of the mode byte is not implemented and reads as zero
	assign csModeWrite = {1'b0, regWrData[6:0]};

	// Status view for software debug of the sequencer
	assign statusWord = {8'h00, sdramEnabled, pending_q, state_q, phase_q};

	// Refresh beats a same-cycle precharge request
	logic refreshStart;
	logic prechargeGo;
	assign refreshStart = pending_q && !accessBusy && sdramEnabled;
	assign prechargeGo = prechargeStart && sdramEnabled && !refreshStart;

	// Phase counts down to zero, so load one less than the cycle count
	logic [3:0] refreshLength;
	logic [3:0] prechargeLength;
	assign refreshLength = 4'(refreshStateCount + `SRTC_RC_BASE - 1);
	assign prechargeLength = 4'(prechargeCycles + `SRTC_RP_BASE - 1);

	// Register file
	always_comb begin
		timing_d = timing_q;
		csMode_d = csMode_q;
		rdData_d = 16'h0000;
		if (regWrite) begin
			case (regAddr)
				`SRTC_ADDR_TIMING: begin
					timing_d = timingWrite;
				end
				`SRTC_ADDR_CSMODE: begin
					csMode_d = csModeWrite;
				end
				default: begin
				end
			endcase
		end
		if (regRead) begin
			case (regAddr)
				`SRTC_ADDR_TIMING: begin
					rdData_d = timing_q;
				end
				`SRTC_ADDR_STATUS: begin
					rdData_d = statusWord;
				end
				`SRTC_ADDR_CSMODE: begin
					rdData_d = {8'h00, csMode_q};
				end
				default: begin
					rdData_d = 16'h0000;
				end
			endcase
		end
	end

	// Refresh sequencing
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		pending_d = pending_q;
		if (intervalExpired) begin
			pending_d = 1'b1;
		end
		case (state_q)
			SRTC_IDLE: begin
				if (refreshStart) begin
					state_d = SRTC_REFRESH;
					phase_d = refreshLength;
					pending_d = intervalExpired;
				end else if (prechargeGo) begin
					state_d = SRTC_PRECHARGE;
					phase_d = prechargeLength;
				end
			end
			SRTC_REFRESH, SRTC_PRECHARGE: begin
				if (phase_q == 4'h0) begin
					state_d = SRTC_IDLE;
				end else begin
					phase_d = phase_q - 4'h1;
				end
			end
			default: begin
				state_d = SRTC_IDLE;
				phase_d = 4'h0;
			end
		endcase
		if (!sdramEnabled) begin
			pending_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			timing_q <= `SRTC_TIMING_RESET;
			csMode_q <= `SRTC_CSMODE_RESET;
			rdData_q <= 16'h0000;
			pending_q <= 1'b0;
			state_q <= SRTC_IDLE;
			phase_q <= 4'h0;
		end else begin
			timing_q <= timing_d;
			csMode_q <= csMode_d;
			rdData_q <= rdData_d;
			pending_q <= pending_d;
			state_q <= state_d;
			phase_q <= phase_d;
		end
	end

	// Refresh issued only in the first refresh cycle, rest is hold-off
	logic firstRefresh_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			firstRefresh_q <= 1'b0;
		end else begin
			firstRefresh_q <= (state_q == SRTC_IDLE) && (state_d == SRTC_REFRESH);
		end
	end

	assign refreshCmd = firstRefresh_q && (state_q == SRTC_REFRESH);
	assign cmdHold = (state_q == SRTC_REFRESH) && !firstRefresh_q;
	assign prechargeActive = (state_q == SRTC_PRECHARGE);
	assign refreshPending = pending_q;
	assign regRdData = rdData_q;
endmodule

// file: srtc_refresh_timing_properties.sv
`timescale 1ns/10ps
module srtc_refresh_checker (
	// Clock, reset and watched ports
	input wire logic core_clk,
	input wire logic rst,
	input wire logic accessBusy,
	input wire logic refreshCmd,
	input wire logic cmdHold,
	input wire logic prechargeActive,
	input wire logic sdramEnabled,
	input wire logic refreshPending,
	input wire logic [1:0] refreshStateCount,
	input wire logic [1:0] prechargeCycles
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_rst; $past(rst) |-> refreshStateCount == 2'h1; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_len; refreshCmd && refreshStateCount == 2'h3 |=> cmdHold[*7] ##1 !cmdHold; endproperty
	a_len: assert property (p_len) else $error("length");
	property p_one; refreshCmd |=> !refreshCmd; endproperty
	a_one: assert property (p_one) else $error("pulse");
	property p_hold; cmdHold |-> !refreshCmd && !prechargeActive; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_pre; $rose(prechargeActive) && prechargeCycles == 2'h3 |-> prechargeActive[*4] ##1 !prechargeActive; endproperty
	a_pre: assert property (p_pre) else $error("precharge");
	property p_wait; refreshCmd |-> !$past(accessBusy); endproperty
	a_wait: assert property (p_wait) else $error("busy");
	property p_pend; refreshCmd |-> $past(refreshPending); endproperty
	a_pend: assert property (p_pend) else $error("pending");
	property p_off; !sdramEnabled [*2] |-> !refreshCmd; endproperty
	a_off: assert property (p_off) else $error("off");
endmodule
bind srtc_refresh_timing srtc_refresh_checker chk (.*);

// file: srtc_sdram_partner.sv
`timescale 1ns/10ps
module srtc_sdram_partner (
	// Clock, reset and controller side
	input wire logic core_clk,
	input wire logic rst,
	input wire logic busyGo,
	input wire logic refreshCmd,
	input wire logic cmdHold,
	output logic accessBusy = 1'h0,
	output logic prechargeStart = 1'h0
);
	always @(posedge core_clk) begin
		accessBusy <= busyGo && !rst && !accessBusy && !refreshCmd && !cmdHold;
		prechargeStart <= accessBusy;
	end
endmodule

// file: srtc_refresh_timing_tb_top.sv
`timescale 1ns/10ps
module srtc_refresh_timing_tb_top;
	logic core_clk = 0, rst = 1, regWrite = 0, regRead = 0, busyGo = 0, rdLag = 0, gapArm = 0;
	logic accessBusy, prechargeStart, refreshCmd, cmdHold, prechargeActive, refreshPending, sdramEnabled;
	logic [1:0] refreshStateCount, prechargeCycles;
	logic [3:0] regAddr = 0;
	logic [15:0] regWrData = 0, regRdData, expQ[$];
	int badCount = 0, checksDone = 0, cyc = 0, seed = 3945, gap = 0, expGap = 0;
	srtc_refresh_timing DUT (.*);
	srtc_sdram_partner partner (.*);
	initial forever #5 core_clk = ~core_clk;
	task automatic finalReport;
		$display("checks %0d bad %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic [1:0] op);
		regAddr <= a;
		regWrData <= d;
		regWrite <= op[0];
		regRead <= op[1];
		if (op[1]) expQ.push_back(d);
		@(posedge core_clk);
	endtask
	always @(posedge core_clk) if (++cyc > 3000) begin
		badCount++;
		finalReport();
	end
	// Read data stands only in the cycle after the strobe
	always @(negedge core_clk) begin
		if (rdLag) begin
			checksDone++;
			if (regRdData !== expQ[0]) begin
				badCount++;
				$display("[FAIL] %0t %h %h", $time, regRdData, expQ[0]);
			end
			expQ.delete(0);
		end
		rdLag = regRead;
	end
	// Spacing of refresh pulses while no access holds them back
	always @(negedge core_clk) begin
		gap++;
		if (refreshCmd === 1'b1) begin
			if (gapArm) begin
				checksDone++;
				if (gap != expGap) begin
					badCount++;
					$display("[FAIL] %0t %h %h", $time, gap, expGap);
				end
			end
			gapArm = (expGap != 0);
			gap = 0;
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		bus(4'h0, 16'h2115, 2'h2);
		bus(4'h7, 16'h0000, 2'h2);
		bus(4'h0, 16'h0730, 2'h1);
		bus(4'h0, 16'h0735, 2'h2);
		bus(4'h2, 16'h003F, 2'h1);
		bus(4'h0, 16'h0000, 2'h0);
		busyGo <= 1'h1;
		repeat (99) @(posedge core_clk);
		busyGo <= 1'h0;
		bus(4'h2, 16'h0000, 2'h1);
		repeat (9) bus(4'h0, 16'h0000, 2'h0);
		$display("refresh done");
		repeat (8) begin
			bus(4'h0, 16'($random(seed)), 2'h1);
			bus(4'h0, regWrData & 16'hFF30 | 16'h0005, 2'h2);
		end
		bus(4'h0, 16'h0000, 2'h0);
		$display("register done");
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		bus(4'h0, 16'h2115, 2'h2);
		bus(4'h0, 16'hF500, 2'h1);
		bus(4'h0, 16'hF505, 2'h2);
		expGap = 61 * 16;
		bus(4'h2, 16'h00BF, 2'h1);
		bus(4'h2, 16'h003F, 2'h2);
		bus(4'h0, 16'h0000, 2'h0);
		repeat (2100) @(posedge core_clk);
		$display("interval done");
		finalReport();
	end
endmodule
